// file: pmwc_pkg.sv
// Package of constants and types for the power mode wake-up controller.
package pmwc_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_STATUS  = 8'h04;
    localparam logic [7:0] OFF_PIN_WEN = 8'h08;
    localparam logic [7:0] OFF_PER_WEN = 8'h0C;
    localparam logic [7:0] OFF_BOD_CTL = 8'h10;
    localparam logic [7:0] OFF_SLP_CFG = 8'h14;
    localparam logic [7:0] OFF_WDT_MOD = 8'h18;
    localparam logic [7:0] OFF_MISC    = 8'h1C;
    localparam logic [7:0] OFF_OFF_WEN = 8'h20;
    localparam logic [7:0] OFF_INT_ST  = 8'h24;
    localparam logic [7:0] OFF_INT_MSK = 8'h28;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_LOCK   = 8;
    localparam int PW_BOD      = 0;
    localparam int PW_WDT      = 1;
    localparam int PW_WKT      = 2;
    localparam int PW_USART    = 3;
    localparam int PW_SPI      = 4;
    localparam int PW_I2C0     = 5;
    localparam int PW_I2C1     = 6;
    localparam int PW_TOUCH    = 7;
    localparam int BOD_IRQ_EN  = 0;
    localparam int BOD_RST_EN  = 1;
    localparam int CFG_BOD_ON  = 0;
    localparam int CFG_OSC_ON  = 1;
    localparam int WDM_EN      = 0;
    localparam int WDM_RST_EN  = 1;
    localparam int WDM_IRQ_EN  = 2;
    localparam int MISC_OSC_EN = 0;
    localparam int MISC_WKT_LP = 1;
    localparam int MISC_TCH_LP = 2;
    localparam int IS_SLEEP    = 0;
    localparam int IS_LOW      = 1;
    localparam int IS_OFF      = 2;
    localparam int IS_REFUSE   = 3;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIB  = 4'h0;
    // ------------------------------------------------------------------
    // Mode encoding
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_DEEP_SLEEP,
        MODE_POWER_DOWN,
        MODE_DEEP_OFF
    } pmwc_mode_t;
endpackage

// file: pmwc_top.sv
// Power mode controller with wake-up gating and a Wishbone slave.
`timescale 1ns/10ps
// Overview of operation
// - Deep power-down cuts power; only the eight wake-up pins end it.
// - With the lock bit set, requests for deep power-down are refused.
// - Wake-up pins never wake from sleep, deep-sleep or power-down.
// - In sleep any core-enabled interrupt resumes the processor.
// - Pin interrupt wakes deep modes if core and pin wake enables set.
// - Brownout interrupt needs both enables, its enable, powered detector.
// - Brownout reset ends deep modes if enabled and detector powered.
// - Watchdog interrupt needs run, enables, powered slow oscillator.
// - Watchdog reset ends deep modes if running, enabled, oscillator powered.
// - Wake timer wakes if oscillator on, low-power clock, enabled, started.
// - Serial interrupts wake deep modes only in slave operation.
// - Touch interrupt wakes if clocked from slow oscillator and enabled.
// - Pin wake from deep power-down needs the deep-off wake enable.
// - Every deep-mode wake interrupt needs wake enable and core enable.
module pmwc_top (
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_ARST_N,
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [7:0]  I_WB_ADR,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic [31:0] I_WB_DAT,
    output logic             O_WB_ACK,
    output logic      [31:0] O_WB_DAT,
    input  wire logic [7:0]  I_PIN_IRQ,
    input  wire logic [7:0]  I_PIN_CORE_INTERRUPT_CONTROLLER_EN,
    input  wire logic [7:0]  I_PER_IRQ,
    input  wire logic [7:0]  I_PER_CORE_INTERRUPT_CONTROLLER_EN,
    input  wire logic        I_BOD_RST,
    input  wire logic        I_WDT_RST,
    input  wire logic        I_WDT_FED,
    input  wire logic        I_WKT_STARTED,
    input  wire logic [3:0]  I_SER_SLAVE,
    input  wire logic [7:0]  I_WAKE_PIN_N,
    output logic      [2:0]  O_MODE,
    output logic             O_CORE_CLK_EN,
    output logic             O_PWR_EN,
    output logic             O_WAKE_RST,
    output logic             O_IRQ
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        pmwc_pkg::pmwc_mode_t mode;
        logic                 ack;
        logic [31:0]          rdat;
        logic                 lock;
        logic [7:0]           pin_wen;
        logic [7:0]           per_wen;
        logic [1:0]           bod_ctl;
        logic [1:0]           slp_cfg;
        logic [2:0]           wdm;
        logic [2:0]           misc;
        logic                 off_wen;
        logic [3:0]           ist;
        logic [3:0]           imsk;
        logic [7:0]           wk_s1;
        logic [7:0]           wk_s2;
        logic                 core_clk;
        logic                 pwr_on;
        logic                 wrst;
        logic                 irq;
    } pmwc_state_t;

    pmwc_state_t st_q;
    pmwc_state_t st_d;
    logic [7:0]  cond;
    logic        low;
    logic        wake_sleep;
    logic        wake_low;
    logic        rst_low;
    logic        wake_off;
    logic        wdt_run;
    logic        req;
    logic        wr;

    // ------------------------------------------------------------------
    // Wake gating
    // ------------------------------------------------------------------
    assign low = (st_q.mode == pmwc_pkg::MODE_DEEP_SLEEP) ||
                 (st_q.mode == pmwc_pkg::MODE_POWER_DOWN);
    assign wdt_run = st_q.wdm[pmwc_pkg::WDM_EN] && I_WDT_FED;
    assign req = I_WB_CYC && I_WB_STB && !st_q.ack;
    assign wr = req && I_WB_WE && I_WB_SEL[0];

    always_comb begin
        cond = 8'h00;
        cond[pmwc_pkg::PW_BOD] = st_q.bod_ctl[pmwc_pkg::BOD_IRQ_EN] &&
                                 st_q.slp_cfg[pmwc_pkg::CFG_BOD_ON];
        cond[pmwc_pkg::PW_WDT] = wdt_run &&
                                 st_q.wdm[pmwc_pkg::WDM_IRQ_EN] &&
                                 st_q.slp_cfg[pmwc_pkg::CFG_OSC_ON];
        cond[pmwc_pkg::PW_WKT] = st_q.misc[pmwc_pkg::MISC_OSC_EN] &&
                                 st_q.misc[pmwc_pkg::MISC_WKT_LP] &&
                                 I_WKT_STARTED;
        cond[pmwc_pkg::PW_USART] = I_SER_SLAVE[0];
        cond[pmwc_pkg::PW_SPI] = I_SER_SLAVE[1];
        cond[pmwc_pkg::PW_I2C0] = I_SER_SLAVE[2];
        cond[pmwc_pkg::PW_I2C1] = I_SER_SLAVE[3];
        cond[pmwc_pkg::PW_TOUCH] = st_q.misc[pmwc_pkg::MISC_TCH_LP];
    end

    // Every deep-mode wake interrupt needs its own wake enable and core enable.
    assign wake_low = |(I_PIN_IRQ & I_PIN_CORE_INTERRUPT_CONTROLLER_EN & st_q.pin_wen) ||
                      |(I_PER_IRQ & I_PER_CORE_INTERRUPT_CONTROLLER_EN & st_q.per_wen & cond);
    assign wake_sleep = |(I_PIN_IRQ & I_PIN_CORE_INTERRUPT_CONTROLLER_EN) ||
                        |(I_PER_IRQ & I_PER_CORE_INTERRUPT_CONTROLLER_EN);
    assign rst_low = (I_BOD_RST && st_q.bod_ctl[pmwc_pkg::BOD_RST_EN] &&
                      st_q.slp_cfg[pmwc_pkg::CFG_BOD_ON]) ||
                     (I_WDT_RST && wdt_run &&
                      st_q.wdm[pmwc_pkg::WDM_RST_EN] &&
                      st_q.slp_cfg[pmwc_pkg::CFG_OSC_ON]);
    // Only the second synchroniser stage is read; pins are active low.
    assign wake_off = st_q.off_wen && (st_q.wk_s2 != 8'hFF);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [3:0] set;
        logic [3:0] clr;
        set = pmwc_pkg::RST_NIB;
        clr = pmwc_pkg::RST_NIB;
        st_d = st_q;
        st_d.wk_s1 = I_WAKE_PIN_N;
        st_d.wk_s2 = st_q.wk_s1;
        st_d.wrst = 1'b0;
        st_d.ack = req;
        if (req) begin
            st_d.rdat = 32'h0000_0000;
            case (I_WB_ADR)
                pmwc_pkg::OFF_CTRL: begin
                    st_d.rdat[2:0] = st_q.mode;
                    st_d.rdat[pmwc_pkg::CTRL_LOCK] = st_q.lock;
                end
                pmwc_pkg::OFF_STATUS:  st_d.rdat[2:0] = st_q.mode;
                pmwc_pkg::OFF_PIN_WEN: st_d.rdat[7:0] = st_q.pin_wen;
                pmwc_pkg::OFF_PER_WEN: st_d.rdat[7:0] = st_q.per_wen;
                pmwc_pkg::OFF_BOD_CTL: st_d.rdat[1:0] = st_q.bod_ctl;
                pmwc_pkg::OFF_SLP_CFG: st_d.rdat[1:0] = st_q.slp_cfg;
                pmwc_pkg::OFF_WDT_MOD: st_d.rdat[2:0] = st_q.wdm;
                pmwc_pkg::OFF_MISC:    st_d.rdat[2:0] = st_q.misc;
                pmwc_pkg::OFF_OFF_WEN: st_d.rdat[0] = st_q.off_wen;
                pmwc_pkg::OFF_INT_ST:  st_d.rdat[3:0] = st_q.ist;
                pmwc_pkg::OFF_INT_MSK: st_d.rdat[3:0] = st_q.imsk;
                default:               st_d.rdat = 32'h0000_0000;
            endcase
        end
        if (req && I_WB_WE && I_WB_SEL[1] &&
            I_WB_ADR == pmwc_pkg::OFF_CTRL) begin
            st_d.lock = I_WB_DAT[pmwc_pkg::CTRL_LOCK];
        end
        if (wr) begin
            case (I_WB_ADR)
                pmwc_pkg::OFF_CTRL: begin
                    case (I_WB_DAT[2:0])
                        3'h1: st_d.mode = pmwc_pkg::MODE_SLEEP;
                        3'h2: st_d.mode = pmwc_pkg::MODE_DEEP_SLEEP;
                        3'h3: st_d.mode = pmwc_pkg::MODE_POWER_DOWN;
                        3'h4: begin
                            // The watchdog and brownout detector need power.
                            if (st_q.lock) begin
                                set[pmwc_pkg::IS_REFUSE] = 1'b1;
                            end else begin
                                st_d.mode = pmwc_pkg::MODE_DEEP_OFF;
                            end
                        end
                        default: st_d.mode = st_q.mode;
                    endcase
                end
                pmwc_pkg::OFF_PIN_WEN: st_d.pin_wen = I_WB_DAT[7:0];
                pmwc_pkg::OFF_PER_WEN: st_d.per_wen = I_WB_DAT[7:0];
                pmwc_pkg::OFF_BOD_CTL: st_d.bod_ctl = I_WB_DAT[1:0];
                pmwc_pkg::OFF_SLP_CFG: st_d.slp_cfg = I_WB_DAT[1:0];
                pmwc_pkg::OFF_WDT_MOD: st_d.wdm = I_WB_DAT[2:0];
                pmwc_pkg::OFF_MISC:    st_d.misc = I_WB_DAT[2:0];
                pmwc_pkg::OFF_OFF_WEN: st_d.off_wen = I_WB_DAT[0];
                pmwc_pkg::OFF_INT_ST:  clr = I_WB_DAT[3:0];
                pmwc_pkg::OFF_INT_MSK: st_d.imsk = I_WB_DAT[3:0];
                default:               st_d.imsk = st_q.imsk;
            endcase
        end
        // ------------------------------------------------------------------
        // Mode exits
        // ------------------------------------------------------------------
        case (st_q.mode)
            pmwc_pkg::MODE_SLEEP: begin
                if (wake_sleep) begin
                    st_d.mode = pmwc_pkg::MODE_RUN;
                    set[pmwc_pkg::IS_SLEEP] = 1'b1;
                end
            end
            pmwc_pkg::MODE_DEEP_SLEEP, pmwc_pkg::MODE_POWER_DOWN: begin
                // Wake-up pins are not looked at here.
                if (wake_low || rst_low) begin
                    st_d.mode = pmwc_pkg::MODE_RUN;
                    st_d.wrst = rst_low;
                    set[pmwc_pkg::IS_LOW] = 1'b1;
                end
            end
            pmwc_pkg::MODE_DEEP_OFF: begin
                // Nothing but the pins may leave; the core restarts by reset.
                if (wake_off) begin
                    st_d.mode = pmwc_pkg::MODE_RUN;
                    st_d.wrst = 1'b1;
                    set[pmwc_pkg::IS_OFF] = 1'b1;
                end else begin
                    // A mode request cannot leave; only a pin may.
                    st_d.mode = pmwc_pkg::MODE_DEEP_OFF;
                end
            end
            default: st_d.mode = st_d.mode;
        endcase
        st_d.core_clk = (st_d.mode == pmwc_pkg::MODE_RUN);
        st_d.pwr_on = (st_d.mode != pmwc_pkg::MODE_DEEP_OFF);
        // A flag set in the cycle of its clear stays set.
        st_d.ist = (st_q.ist & ~clr) | set;
        st_d.irq = |(st_d.ist & st_d.imsk);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_q <= '0;
            st_q.mode <= pmwc_pkg::MODE_RUN;
            st_q.wk_s1 <= 8'hFF;
            st_q.wk_s2 <= 8'hFF;
            st_q.core_clk <= 1'b1;
            st_q.pwr_on <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign O_WB_ACK = st_q.ack;
    assign O_WB_DAT = st_q.rdat;
    assign O_MODE = st_q.mode;
    assign O_CORE_CLK_EN = st_q.core_clk;
    assign O_PWR_EN = st_q.pwr_on;
    assign O_WAKE_RST = st_q.wrst;
    assign O_IRQ = st_q.irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_ARST_N);

    sequence s_run_exit;
        O_MODE == 3'h0 && O_CORE_CLK_EN && O_PWR_EN;
    endsequence
    sequence s_rst_pulse;
        O_WAKE_RST ##1 !O_WAKE_RST;
    endsequence

    property p_off_hold;
        O_MODE == 3'h4 && !wake_off |=> O_MODE == 3'h4 && !O_PWR_EN;
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("Deep power-down left without a pin wake.");

    property p_lock;
        wr && I_WB_ADR == 8'h00 && I_WB_DAT[2:0] == 3'h4 && st_q.lock &&
        O_MODE != 3'h4 |=> O_MODE != 3'h4 ##0 st_q.ist[3];
    endproperty
    a_lock: assert property (p_lock)
        else $error("Locked deep power-down entry was not refused.");

    property p_hold_low;
        low && !wake_low && !rst_low &&
        !(wr && I_WB_ADR == pmwc_pkg::OFF_CTRL) |=> $stable(O_MODE);
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("Deep mode left without a gated wake event.");

    property p_sleep;
        O_MODE == 3'h1 && wake_sleep |=> s_run_exit;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("Enabled interrupt did not resume from sleep.");

    property p_sleep_hold;
        O_MODE == 3'h1 && !wake_sleep && !wr |=> O_MODE == 3'h1;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("Sleep left without an enabled interrupt.");

    property p_pin;
        low && |(I_PIN_IRQ & I_PIN_CORE_INTERRUPT_CONTROLLER_EN & st_q.pin_wen) |=> s_run_exit;
    endproperty
    a_pin: assert property (p_pin)
        else $error("Gated pin interrupt did not wake.");

    property p_bod_irq;
        low && I_PER_IRQ[0] && !st_q.bod_ctl[0] && !rst_low &&
        I_PER_IRQ[7:1] == 7'h00 && I_PIN_IRQ == 8'h00 &&
        !(wr && I_WB_ADR == pmwc_pkg::OFF_CTRL) |=> $stable(O_MODE);
    endproperty
    a_bod_irq: assert property (p_bod_irq)
        else $error("Brownout interrupt woke while disabled.");

    property p_reset_exit;
        low && rst_low |=> s_rst_pulse;
    endproperty
    a_reset_exit: assert property (p_reset_exit)
        else $error("Enabled reset did not end the deep mode.");

    property p_off_wake;
        O_MODE == 3'h4 && wake_off |=> s_run_exit ##0 s_rst_pulse;
    endproperty
    a_off_wake: assert property (p_off_wake)
        else $error("Enabled wake-up pin did not leave deep power-down.");
endmodule

// file: pmwc_src.sv
// Behavioural model of the on-chip wake sources and the wake-up pins.
`timescale 1ns/10ps
module pmwc_src (
    input  wire logic       i_clk,
    input  wire logic       i_go,
    input  wire logic [2:0] i_src,
    input  wire logic [2:0] i_idx,
    input  wire logic       i_ready,
    output logic      [7:0] o_pin_irq,
    output logic      [7:0] o_per_irq,
    output logic            o_bod_rst,
    output logic            o_wdt_rst,
    output logic            o_wdt_fed,
    output logic            o_wkt_started,
    output logic      [3:0] o_ser_slave,
    output logic      [7:0] o_wake_pin_n
);
    logic [1:0] pin_cnt;
    // Slave mode, the watchdog feed and the wake-timer start are granted as one condition.
    assign o_ser_slave   = {4{i_ready}};
    assign o_wdt_fed     = i_ready;
    assign o_wkt_started = i_ready;
    initial begin
        {o_pin_irq, o_per_irq, o_bod_rst, o_wdt_rst, pin_cnt} = '0;
        o_wake_pin_n = 8'hFF;
    end
    // Interrupt and reset events last one cycle so a later mode request is not woken at once; wake pins stay low four cycles.
    always @(posedge i_clk) begin
        o_pin_irq <= 8'h00;
        o_per_irq <= 8'h00;
        o_bod_rst <= 1'b0;
        o_wdt_rst <= 1'b0;
        if (pin_cnt != 2'h0) begin
            pin_cnt <= pin_cnt - 2'h1;
        end else begin
            o_wake_pin_n <= 8'hFF;
        end
        if (i_go) begin
            case (i_src)
                3'h0: o_pin_irq[i_idx] <= 1'b1;
                3'h1: o_per_irq[i_idx] <= 1'b1;
                3'h2: o_bod_rst <= 1'b1;
                3'h3: o_wdt_rst <= 1'b1;
                default: begin
                    o_wake_pin_n <= ~(8'h01 << i_idx);
                    pin_cnt      <= 2'h3;
                end
            endcase
        end
    end
endmodule

// file: pmwc_top_tb.sv
// Self-checking testbench for the power mode wake-up controller.
`timescale 1ns/10ps
module pmwc_top_tb;
    logic        clk, arst_n, cyc, stb, we, ack, go, rdy, clk_en, pwr_en;
    logic        wrst, irq, bod_rst, wdt_rst, fed, started;
    logic [7:0]  adr, pin_en, per_en, pin_irq, per_irq, wpin_n;
    logic [3:0]  sel, slave;
    logic [2:0]  src, idx, mode, i;
    logic [31:0] wdat, rdat, r;
    logic [31:0] exp_q[$];
    logic [7:0]  offs[8];
    logic [7:0]  msks[8];
    int          fail_count, num_checks, wrst_cnt, c;

    pmwc_top dut (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_WB_CYC(cyc),
        .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
        .I_WB_DAT(wdat), .O_WB_ACK(ack), .O_WB_DAT(rdat),
        .I_PIN_IRQ(pin_irq), .I_PIN_CORE_INTERRUPT_CONTROLLER_EN(pin_en), .I_PER_IRQ(per_irq),
        .I_PER_CORE_INTERRUPT_CONTROLLER_EN(per_en), .I_BOD_RST(bod_rst), .I_WDT_RST(wdt_rst),
        .I_WDT_FED(fed), .I_WKT_STARTED(started), .I_SER_SLAVE(slave),
        .I_WAKE_PIN_N(wpin_n), .O_MODE(mode), .O_CORE_CLK_EN(clk_en),
        .O_PWR_EN(pwr_en), .O_WAKE_RST(wrst), .O_IRQ(irq));
    pmwc_src src_m (.i_clk(clk), .i_go(go), .i_src(src), .i_idx(idx),
        .i_ready(rdy), .o_pin_irq(pin_irq), .o_per_irq(per_irq),
        .o_bod_rst(bod_rst), .o_wdt_rst(wdt_rst), .o_wdt_fed(fed),
        .o_wkt_started(started), .o_ser_slave(slave),
        .o_wake_pin_n(wpin_n));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hF;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        check("bus ack", 32'(ack), 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic mode_is(input logic [2:0] m);
        rd(pmwc_pkg::OFF_STATUS, {29'h0, m});
        check("mode pin", 32'(mode), {29'h0, m});
    endtask
    task automatic cfg(input logic [31:0] b, s, w, m);
        wr(pmwc_pkg::OFF_BOD_CTL, b);
        wr(pmwc_pkg::OFF_SLP_CFG, s);
        wr(pmwc_pkg::OFF_WDT_MOD, w);
        wr(pmwc_pkg::OFF_MISC, m);
    endtask
    // The settle time covers the two pin synchroniser stages.
    task automatic fire(input logic [2:0] s, input logic [2:0] x);
        @(posedge clk);
        go  <= 1'b1;
        src <= s;
        idx <= x;
        @(posedge clk);
        go <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, monitor and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            check("read data", rdat, exp_q.pop_front());
        end
        if (wrst === 1'b1) begin
            wrst_cnt++;
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        {cyc, stb, we, go, rdy, adr, sel, wdat, src, idx} = '0;
        {pin_en, per_en, fail_count, num_checks, wrst_cnt} = '0;
        arst_n = 1'b0;
        offs = '{pmwc_pkg::OFF_PIN_WEN, pmwc_pkg::OFF_PER_WEN,
                 pmwc_pkg::OFF_BOD_CTL, pmwc_pkg::OFF_SLP_CFG,
                 pmwc_pkg::OFF_WDT_MOD, pmwc_pkg::OFF_MISC,
                 pmwc_pkg::OFF_OFF_WEN, pmwc_pkg::OFF_INT_MSK};
        msks = '{8'hFF, 8'hFF, 8'h03, 8'h03, 8'h07, 8'h07, 8'h01, 8'h0F};
        void'($urandom(32'h8570e104));
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        for (int k = 0; k < 13; k++) begin
            rd(8'(k * 4), 32'h0);
        end
        for (int k = 0; k < 8; k++) begin
            r = $urandom;
            wr(offs[k], r);
            rd(offs[k], r & {24'h0, msks[k]});
        end
        wr(8'h30, 32'hFFFFFFFF);
        rd(8'h30, 32'h0);
        $display("register test done");
        wr(pmwc_pkg::OFF_CTRL, 32'h1);
        check("core clock", 32'(clk_en), 32'h0);
        i = 3'($urandom);
        fire(3'h0, i);
        mode_is(3'h1);
        pin_en <= 8'hFF;
        fire(3'h0, i);
        mode_is(3'h0);
        check("core clock", 32'(clk_en), 32'h1);
        wr(pmwc_pkg::OFF_PIN_WEN, 32'h0);
        wr(pmwc_pkg::OFF_OFF_WEN, 32'h1);
        wr(pmwc_pkg::OFF_CTRL, 32'h2);
        fire(3'h0, i);
        mode_is(3'h2);
        fire(3'h4, i);
        mode_is(3'h2);
        wr(pmwc_pkg::OFF_PIN_WEN, 32'h1 << i);
        pin_en <= ~(8'h01 << i);
        fire(3'h0, i);
        mode_is(3'h2);
        pin_en <= 8'hFF;
        fire(3'h0, i);
        mode_is(3'h0);
        $display("sleep and pin test done");
        cfg(32'h1, 32'h3, 32'h5, 32'h7);
        wr(pmwc_pkg::OFF_PER_WEN, 32'hFF);
        per_en <= 8'hFF;
        rdy    <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            wr(pmwc_pkg::OFF_CTRL, 32'h3);
            fire(3'h1, 3'(k));
            mode_is(3'h0);
        end
        cfg(32'h1, 32'h0, 32'h5, 32'h0);
        rdy <= 1'b0;
        wr(pmwc_pkg::OFF_CTRL, 32'h3);
        for (int k = 0; k < 8; k++) begin
            fire(3'h1, 3'(k));
            mode_is(3'h3);
        end
        cfg(32'h0, 32'h3, 32'h1, 32'h7);
        rdy <= 1'b1;
        wr(pmwc_pkg::OFF_CTRL, 32'h2);
        fire(3'h2, 3'h0);
        fire(3'h3, 3'h0);
        fire(3'h1, 3'h0);
        mode_is(3'h2);
        cfg(32'h2, 32'h3, 32'h3, 32'h7);
        c = wrst_cnt;
        fire(3'h2, 3'h0);
        mode_is(3'h0);
        wr(pmwc_pkg::OFF_CTRL, 32'h3);
        fire(3'h3, 3'h0);
        mode_is(3'h0);
        check("reset exits", 32'(wrst_cnt - c), 32'h2);
        $display("peripheral and reset test done");
        wr(pmwc_pkg::OFF_INT_ST, 32'hF);
        wr(pmwc_pkg::OFF_INT_MSK, 32'h8);
        wr(pmwc_pkg::OFF_CTRL, 32'h100);
        wr(pmwc_pkg::OFF_CTRL, 32'h104);
        rd(pmwc_pkg::OFF_CTRL, 32'h100);
        rd(pmwc_pkg::OFF_INT_ST, 32'h8);
        check("irq", 32'(irq), 32'h1);
        wr(pmwc_pkg::OFF_INT_MSK, 32'h0);
        repeat (2) @(posedge clk);
        check("irq", 32'(irq), 32'h0);
        wr(pmwc_pkg::OFF_INT_MSK, 32'h8);
        wr(pmwc_pkg::OFF_INT_ST, 32'h8);
        rd(pmwc_pkg::OFF_INT_ST, 32'h0);
        check("irq", 32'(irq), 32'h0);
        wr(pmwc_pkg::OFF_CTRL, 32'h0);
        wr(pmwc_pkg::OFF_OFF_WEN, 32'h0);
        wr(pmwc_pkg::OFF_CTRL, 32'h4);
        check("power", 32'(pwr_en), 32'h0);
        fire(3'h0, i);
        fire(3'h4, i);
        mode_is(3'h4);
        wr(pmwc_pkg::OFF_OFF_WEN, 32'h1);
        c = wrst_cnt;
        fire(3'h4, i);
        mode_is(3'h0);
        check("power", 32'(pwr_en), 32'h1);
        check("off exit pulse", 32'(wrst_cnt - c), 32'h1);
        $display("lock and deep off test done");
        finish_test();
    end
endmodule
